// file: common/sks_pkg.sv
// Purpose: shared constants and carriers for the socket send command block
// Assumes: one socket, single 200 MHz clock
// Notes:   command codes, modes and states live here
package sks_pkg;
   // ----------------------------------------------------------------
   // command codes, socket modes and socket states
   // ----------------------------------------------------------------
   localparam logic [7:0] SKS_CMD_NONE      = 8'h00;
   localparam logic [7:0] SKS_CMD_SEND      = 8'h20;
   localparam logic [7:0] SKS_CMD_SEND_KHW  = 8'h21;
   localparam logic [7:0] SKS_CMD_KEEPALIVE = 8'h22;
   localparam logic [3:0] SKS_MODE_TCP      = 4'h1;
   localparam logic [3:0] SKS_MODE_UDP      = 4'h2;
   localparam logic [3:0] SKS_MODE_IP_RAW   = 4'h3;
   localparam logic [3:0] SKS_MODE_MAC_RAW  = 4'h4;
   localparam logic [7:0] SKS_STATE_CLOSED  = 8'h00;
   localparam logic [7:0] SKS_STATE_OPEN    = 8'h17;
   // ----------------------------------------------------------------
   // sizes, reset values and timing
   // ----------------------------------------------------------------
   localparam int          SKS_SIZE_W        = 16;
   localparam logic [15:0] SKS_TX_FREE_RESET = 16'h2000;
   localparam logic [15:0] SKS_MSS_DEFAULT   = 16'h05B4;
   localparam int          SKS_CLK_MHZ       = 200;
   localparam int          SKS_KEEP_US       = 50;
   localparam int          SKS_KEEP_CYCLES   = SKS_KEEP_US * SKS_CLK_MHZ;
   localparam int          SKS_ACK_US        = 200;
   localparam int          SKS_ACK_CYCLES    = SKS_ACK_US * SKS_CLK_MHZ;
   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        valid;  // segment request, held until seg_ready
      logic        keep;   // keep-alive probe, no payload
      logic        skip_resolve; // use stored hardware address
      logic [15:0] len;    // payload bytes
      logic [47:0] dest_hw; // destination hardware address
   } sks_seg_t;
   typedef struct packed {
      logic timeout;  // ack wait expired
      logic send_done; // send complete
   } sks_irq_t;
endpackage : sks_pkg

// file: rtl/sks_timer.sv
// Purpose: reloadable down counter with expiry pulse
// Assumes: load has priority over counting
// Notes:   used for keep-alive period and ack wait
`timescale 1ns/10ps
module sks_timer #(
   parameter int W = 24
) (
   input  wire logic         clk,    // core clock
   input  wire logic         rstn,   // sync reset, active low
   input  wire logic         load,   // start or restart
   input  wire logic         stop,   // abandon counting
   input  wire logic [W-1:0] period, // cycles to expiry
   output logic              expired // one-cycle expiry pulse
);
   logic [W-1:0] cnt_reg;
   logic         run_reg;
   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (load) begin
            cnt_reg <= period;
            run_reg <= 1'b1;
         end else if (stop) begin
            run_reg <= 1'b0;
         end else if (run_reg) begin
            if (cnt_reg <= W'(1)) begin
               run_reg <= 1'b0;
               expired <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - W'(1);
            end
         end
      end
   end
endmodule : sks_timer

// file: rtl/sks_send_ctrl.sv
// Purpose: per-socket transmit command interpreter (send, send with known
//          hardware address, keep-alive)
// Assumes: host pulses cmd_we with a command; transmitter takes segments on
//          seg_ready; peer acks arrive as ack_valid pulses
// Notes:   the command register clears to zero once a command is taken
`timescale 1ns/10ps
// Notes on behaviour
// - TCP ack restores free size by bytes
// - no ack: timeout flag, socket closed
// - datagram modes: flag send done, then restore
// - known-address send only in UDP, IP-raw
// - known-address send skips address resolution
// - keep-alive probes repeat after command
// - keep-alive legal only in TCP
// - TCP/UDP data split into segment size
module sks_send_ctrl
   import sks_pkg::*;
#(
   parameter int          KEEP_CYCLES = SKS_KEEP_CYCLES,
   parameter int          ACK_CYCLES  = SKS_ACK_CYCLES,
   parameter logic [15:0] MSS         = SKS_MSS_DEFAULT
) (
   input  wire logic                 clk,               // core clock
   input  wire logic                 rstn,              // sync reset, active low
   input  wire logic                 cmd_we,            // host writes command
   input  wire logic [7:0]           cmd_in,            // command code
   input  wire logic [3:0]           sock_mode,         // socket protocol mode
   input  wire logic [15:0]          send_len,          // bytes to send
   input  wire logic [47:0]          sock_dest_hw_addr, // stored peer address
   input  wire logic                 irq_clr_done,      // host clears send done
   input  wire logic                 irq_clr_timeout,   // host clears timeout
   input  wire logic                 sock_open,         // socket opened by host
   input  wire logic                 seg_ready,         // transmitter takes seg
   input  wire logic                 ack_valid,         // peer acked bytes
   input  wire logic [15:0]          ack_bytes,         // bytes acked
   output logic [7:0]                cmd_reg,           // command register view
   output logic [15:0]               sock_tx_free_size, // free tx space
   output sks_pkg::sks_irq_t         sock_irq_flags,    // sticky flags
   output logic [7:0]                sock_state,        // socket state
   output sks_pkg::sks_seg_t         seg_out,           // segment request
   output logic                      cmd_rejected       // illegal command pulse
);
   import sks_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_SEG, ST_WAIT_ACK, ST_DONE} sks_fsm_t;

   sks_fsm_t    st_reg;
   logic [15:0] remain_reg;
   logic [15:0] sent_reg;    // bytes sent, awaiting credit
   logic        khw_reg;     // skip address resolution
   logic        keep_reg;    // keep-alive running
   logic        keep_req_reg;
   logic        ever_sent_reg;
   logic        keep_exp;
   logic        ack_exp;
   logic        is_tcp;
   logic        legal;
   logic        accept;
   logic        seg_fire;
   logic [15:0] seg_len;

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   function automatic logic cmd_legal(input logic [7:0] c, input logic [3:0] m,
                                      input logic sent);
      if (c == SKS_CMD_SEND)
         return 1'b1;
      else if (c == SKS_CMD_SEND_KHW)
         return (m == SKS_MODE_UDP) || (m == SKS_MODE_IP_RAW);
      else if (c == SKS_CMD_KEEPALIVE)
         return (m == SKS_MODE_TCP) && sent;
      else
         return 1'b0;
   endfunction : cmd_legal

   function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
      return (a < b) ? a : b;
   endfunction : min16

   assign is_tcp = (sock_mode == SKS_MODE_TCP);
   assign legal  = cmd_legal(cmd_reg, sock_mode, ever_sent_reg);
   // commands only taken while idle; others wait in the register
   assign accept = (cmd_reg != SKS_CMD_NONE) && (st_reg == ST_IDLE);
   // raw modes rely on host pre-splitting, so only TCP/UDP are cut here
   assign seg_len = ((sock_mode == SKS_MODE_TCP) || (sock_mode == SKS_MODE_UDP)) ?
                    min16(remain_reg, MSS) : remain_reg;
   assign seg_fire = seg_out.valid && seg_ready;

   // ----------------------------------------------------------------
   // command register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cmd_reg      <= SKS_CMD_NONE;
         cmd_rejected <= 1'b0;
      end else begin
         cmd_rejected <= accept && !legal;
         if (accept)
            cmd_reg <= SKS_CMD_NONE;
         else if (cmd_we && cmd_reg == SKS_CMD_NONE)
            cmd_reg <= cmd_in;
      end
   end

   // ----------------------------------------------------------------
   // send sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_reg        <= ST_IDLE;
         remain_reg    <= '0;
         khw_reg       <= 1'b0;
         ever_sent_reg <= 1'b0;
      end else begin
         case (st_reg)
            ST_IDLE: begin
               if (accept && legal && cmd_reg != SKS_CMD_KEEPALIVE && send_len != 16'h0000) begin
                  remain_reg <= send_len;
                  khw_reg    <= (cmd_reg == SKS_CMD_SEND_KHW);
                  st_reg     <= ST_SEG;
               end
            end
            ST_SEG: begin
               if (seg_fire && !seg_out.keep) begin
                  remain_reg    <= remain_reg - seg_len;
                  ever_sent_reg <= 1'b1;
                  if (remain_reg == seg_len)
                     st_reg <= is_tcp ? ST_WAIT_ACK : ST_DONE;
               end
            end
            ST_WAIT_ACK: begin
               if (ack_exp || sent_reg == 16'h0000)
                  st_reg <= ST_IDLE;
            end
            ST_DONE: st_reg <= ST_IDLE;
            default: st_reg <= ST_IDLE;
         endcase
         if (!sock_open)
            ever_sent_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // segment output; keep-alive probes slip in between sends
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         seg_out <= '0;
      end else if (!seg_out.valid || seg_ready) begin
         seg_out.valid        <= 1'b0;
         seg_out.keep         <= 1'b0;
         seg_out.skip_resolve <= 1'b0;
         seg_out.len          <= '0;
         seg_out.dest_hw      <= sock_dest_hw_addr;
         if (st_reg == ST_SEG && !seg_out.valid) begin
            seg_out.valid        <= 1'b1;
            seg_out.len          <= seg_len;
            seg_out.skip_resolve <= khw_reg;
         end else if (keep_req_reg && st_reg == ST_IDLE && !seg_out.valid) begin
            seg_out.valid <= 1'b1;
            seg_out.keep  <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // keep-alive: periodic probes until the socket closes
   // ----------------------------------------------------------------
   sks_timer #(.W(32)) u_keep (
      .clk     (clk),
      .rstn    (rstn),
      .load    ((accept && legal && cmd_reg == SKS_CMD_KEEPALIVE) ||
                (keep_reg && keep_exp)),
      .stop    (!keep_reg),
      .period  (32'(KEEP_CYCLES)),
      .expired (keep_exp)
   );

   always_ff @(posedge clk) begin
      if (!rstn) begin
         keep_reg     <= 1'b0;
         keep_req_reg <= 1'b0;
      end else begin
         if (accept && legal && cmd_reg == SKS_CMD_KEEPALIVE) begin
            keep_reg     <= 1'b1;
            keep_req_reg <= 1'b1;
         end else if (sock_state == SKS_STATE_CLOSED) begin
            keep_reg     <= 1'b0;
            keep_req_reg <= 1'b0;
         end else if (keep_reg && keep_exp) begin
            keep_req_reg <= 1'b1;
         end else if (seg_fire && seg_out.keep) begin
            keep_req_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // ack wait timer; restarted by every ack
   // ----------------------------------------------------------------
   sks_timer #(.W(32)) u_ack (
      .clk     (clk),
      .rstn    (rstn),
      .load    ((st_reg == ST_SEG && seg_fire && is_tcp) ||
                (ack_valid && sent_reg != 16'h0000)),
      .stop    (st_reg == ST_IDLE),
      .period  (32'(ACK_CYCLES)),
      .expired (ack_exp)
   );

   // ----------------------------------------------------------------
   // free size accounting; credit per ack (TCP) or after done (datagram)
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sock_tx_free_size <= SKS_TX_FREE_RESET;
         sent_reg          <= '0;
      end else if (accept && legal && cmd_reg != SKS_CMD_KEEPALIVE) begin
         sock_tx_free_size <= sock_tx_free_size - min16(send_len, sock_tx_free_size);
         sent_reg          <= min16(send_len, sock_tx_free_size);
      end else if (is_tcp && ack_valid && st_reg != ST_IDLE) begin
         sock_tx_free_size <= sock_tx_free_size + min16(ack_bytes, sent_reg);
         sent_reg          <= sent_reg - min16(ack_bytes, sent_reg);
      end else if (st_reg == ST_DONE && !is_tcp && sock_irq_flags.send_done) begin
         sock_tx_free_size <= sock_tx_free_size + sent_reg;
         sent_reg          <= '0;
      end
   end

   // ----------------------------------------------------------------
   // sticky flags: a set in the same cycle as a clear wins
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sock_irq_flags <= '0;
      end else begin
         // tcp reports done only once every byte is acked, never on the last segment
         if ((st_reg == ST_SEG && seg_fire && !seg_out.keep && !is_tcp &&
              remain_reg == seg_len) ||
             (st_reg == ST_WAIT_ACK && sent_reg == 16'h0000))
            sock_irq_flags.send_done <= 1'b1;
         else if (irq_clr_done)
            sock_irq_flags.send_done <= 1'b0;
         if (st_reg == ST_WAIT_ACK && ack_exp && sent_reg != 16'h0000)
            sock_irq_flags.timeout <= 1'b1;
         else if (irq_clr_timeout)
            sock_irq_flags.timeout <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // socket state
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn)
         sock_state <= SKS_STATE_CLOSED;
      else if (st_reg == ST_WAIT_ACK && ack_exp && sent_reg != 16'h0000)
         sock_state <= SKS_STATE_CLOSED;
      else if (sock_open)
         sock_state <= SKS_STATE_OPEN;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_ack_timeout;
      st_reg == ST_WAIT_ACK && ack_exp && sent_reg != 16'h0000;
   endsequence

   AST_TIMEOUT_CLOSES: assert property (@(posedge clk) disable iff (!rstn)
      s_ack_timeout |=> sock_irq_flags.timeout && sock_state == SKS_STATE_CLOSED)
      else $error("timeout did not set flag and close");
   AST_CMD_CLEARED: assert property (@(posedge clk) disable iff (!rstn)
      accept |=> cmd_reg == SKS_CMD_NONE)
      else $error("command register not cleared");
   AST_KHW_MODE: assert property (@(posedge clk) disable iff (!rstn)
      accept && cmd_reg == SKS_CMD_SEND_KHW && sock_mode == SKS_MODE_TCP |=> cmd_rejected)
      else $error("known-address send taken in TCP");
   AST_KEEP_MODE: assert property (@(posedge clk) disable iff (!rstn)
      accept && cmd_reg == SKS_CMD_KEEPALIVE && !is_tcp |=> !keep_reg)
      else $error("keep-alive started outside TCP");
   AST_SEG_MSS: assert property (@(posedge clk) disable iff (!rstn)
      seg_out.valid && !seg_out.keep && (sock_mode == SKS_MODE_TCP || sock_mode == SKS_MODE_UDP)
      |-> seg_out.len <= MSS)
      else $error("segment above segment size");
   AST_KHW_SKIP: assert property (@(posedge clk) disable iff (!rstn)
      seg_out.valid && seg_out.skip_resolve |-> khw_reg && seg_out.dest_hw == sock_dest_hw_addr)
      else $error("skip flag without known-address send");
   AST_ACK_CREDIT: assert property (@(posedge clk) disable iff (!rstn)
      is_tcp && ack_valid && st_reg != ST_IDLE && !accept |=>
      sock_tx_free_size == $past(sock_tx_free_size) + min16($past(ack_bytes), $past(sent_reg)))
      else $error("ack did not restore free size");
   AST_DGRAM_ORDER: assert property (@(posedge clk) disable iff (!rstn)
      !is_tcp && sock_tx_free_size > $past(sock_tx_free_size) |-> $past(sock_irq_flags.send_done))
      else $error("free size restored before send done");
   AST_KEEP_PROBE: assert property (@(posedge clk) disable iff (!rstn)
      keep_reg && keep_exp && sock_state != SKS_STATE_CLOSED |=> keep_req_reg)
      else $error("keep-alive probe not requested");
endmodule : sks_send_ctrl

// file: dv/sks_peer_model.sv
// Purpose: far-side transmitter and peer station model
// Assumes: one segment taken per ready pulse, tcp peer acks each data segment
// Notes:   stall length and ack enable come from the bench
`timescale 1ns/10ps
module sks_peer_model
   import sks_pkg::*;
(
   input  wire logic         clk,       // core clock
   input  wire logic         rstn,      // sync reset, active low
   input  sks_pkg::sks_seg_t seg_in,    // segment request from block
   input  wire logic [7:0]   slow,      // stall cycles before ready
   input  wire logic         ack_en,    // peer answers with acks
   output logic              seg_ready, // segment taken this cycle
   output logic              ack_valid, // ack pulse
   output logic [15:0]       ack_bytes, // acked byte count
   output sks_pkg::sks_seg_t last_seg,  // last segment taken
   output int                seg_cnt,   // data segments taken
   output int                keep_cnt   // keep-alive probes taken
);
   logic [7:0] stall_cnt;
   logic       take;
   // --------------------------------------------------------------
   // handshake and acks
   // --------------------------------------------------------------
   assign take = seg_in.valid && seg_ready;
   // ready after the stall, one idle cycle between takes
   always_ff @(posedge clk) begin
      if (!rstn) begin
         seg_ready <= 1'b0;
         stall_cnt <= 8'h00;
      end else begin
         seg_ready <= seg_in.valid && !seg_ready && stall_cnt >= slow;
         stall_cnt <= (seg_in.valid && !seg_ready) ? stall_cnt + 8'h01 : 8'h00;
      end
   end
   // stale count is inverted so a missed valid never sees a good value
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ack_valid <= 1'b0;
         ack_bytes <= 16'h0000;
      end else begin
         ack_valid <= take && ack_en && !seg_in.keep;
         ack_bytes <= (take && !seg_in.keep) ? seg_in.len : ~ack_bytes;
      end
   end
   // tallies for the bench
   always_ff @(posedge clk) begin
      if (!rstn) begin
         seg_cnt  <= 0;
         keep_cnt <= 0;
      end else if (take) begin
         last_seg <= seg_in;
         seg_cnt  <= seg_cnt + (seg_in.keep ? 0 : 1);
         keep_cnt <= keep_cnt + (seg_in.keep ? 1 : 0);
      end
   end
endmodule : sks_peer_model

// file: dv/sks_send_ctrl_bench.sv
// Purpose: self-checking bench for the socket send command block
// Assumes: shortened keep-alive and ack wait counts
// Notes:   table rows first, then timeout, second reset and keep-alive
`timescale 1ns/10ps
module sks_send_ctrl_bench;
   import sks_pkg::*;
   localparam int          KEEP_SIM = 20;
   localparam int          ACK_SIM  = 50;
   localparam logic [47:0] DEST     = 48'h02AB_CD00_1234;
   localparam int          CHK_W    = $bits(sks_seg_t);
   typedef struct {
      logic [3:0]  mode;
      logic [7:0]  cmd;
      logic [15:0] len;
      int          segs;
      bit          rej;
      logic [7:0]  slow;
   } sks_row_t;
   logic        clk, rstn, cmd_we, irq_clr_done, irq_clr_timeout, sock_open;
   logic        seg_ready, ack_valid, ack_en, cmd_rejected;
   logic [3:0]  sock_mode;
   logic [7:0]  cmd_in, cmd_reg, sock_state, slow;
   logic [15:0] send_len, ack_bytes, sock_tx_free_size;
   sks_irq_t    sock_irq_flags;
   sks_seg_t    seg_out, last_seg;
   int          err_count, checks_done, seg_cnt, keep_cnt, n0, cyc;
   bit          rej, done;
   sks_row_t    rows[11];

   sks_send_ctrl #(.KEEP_CYCLES(KEEP_SIM), .ACK_CYCLES(ACK_SIM)) DUT (.clk(clk), .rstn(rstn),
      .cmd_we(cmd_we), .cmd_in(cmd_in), .sock_mode(sock_mode), .send_len(send_len),
      .sock_dest_hw_addr(DEST), .irq_clr_done(irq_clr_done),
      .irq_clr_timeout(irq_clr_timeout), .sock_open(sock_open), .seg_ready(seg_ready),
      .ack_valid(ack_valid), .ack_bytes(ack_bytes), .cmd_reg(cmd_reg),
      .sock_tx_free_size(sock_tx_free_size), .sock_irq_flags(sock_irq_flags),
      .sock_state(sock_state), .seg_out(seg_out), .cmd_rejected(cmd_rejected));
   sks_peer_model peer (.clk(clk), .rstn(rstn), .seg_in(seg_out), .slow(slow),
      .ack_en(ack_en), .seg_ready(seg_ready), .ack_valid(ack_valid), .ack_bytes(ack_bytes),
      .last_seg(last_seg), .seg_cnt(seg_cnt), .keep_cnt(keep_cnt));

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic check(input logic [CHK_W-1:0] seen, input logic [CHK_W-1:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   function automatic logic [15:0] exp_last(input logic [15:0] len);
      return (len % SKS_MSS_DEFAULT == 16'h0000) ? SKS_MSS_DEFAULT : len % SKS_MSS_DEFAULT;
   endfunction : exp_last
   // issue one command, then watch until it ends or lim runs out
   task automatic run_cmd(input logic [7:0] cmd, input logic [15:0] len, input int lim);
      int clr_at;
      clr_at = 99;
      rej = 1'b0;
      done = 1'b0;
      cyc = 0;
      cmd_in <= cmd;
      send_len <= len;
      cmd_we <= 1'b1;
      @(posedge clk);
      cmd_we <= 1'b0;
      #1;
      check(cmd_reg, cmd);
      while (cyc < lim && !rej && !done && sock_irq_flags.timeout !== 1'b1) begin
         @(posedge clk);
         #1;
         cyc++;
         if (cmd_reg === 8'h00 && clr_at == 99) clr_at = cyc;
         rej = cmd_rejected === 1'b1;
         done = sock_irq_flags.send_done === 1'b1;
      end
      check(clr_at <= 3, 1'b1);
      if (lim > 10 && cyc >= lim) begin
         err_count++;
         $display("wrong value at %0t: no completion", $time);
         final_report();
      end
   endtask : run_cmd
   // pulse the flag clears, {timeout, send_done}
   task automatic clear(input logic [1:0] which);
      {irq_clr_timeout, irq_clr_done} <= which;
      @(posedge clk);
      {irq_clr_timeout, irq_clr_done} <= 2'b00;
      @(posedge clk);
      #1;
      check(sock_irq_flags, 2'b00);
   endtask : clear

   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      rows = '{
         '{SKS_MODE_UDP,     SKS_CMD_SEND,      16'h0064, 1, 1'b0, 8'h00},
         '{SKS_MODE_UDP,     SKS_CMD_SEND,      16'h0BB8, 3, 1'b0, 8'h03},
         '{SKS_MODE_TCP,     SKS_CMD_SEND,      16'h05B4, 1, 1'b0, 8'h00},
         '{SKS_MODE_TCP,     SKS_CMD_SEND,      16'h05B5, 2, 1'b0, 8'h02},
         '{SKS_MODE_IP_RAW,  SKS_CMD_SEND,      16'h00C8, 1, 1'b0, 8'h01},
         '{SKS_MODE_MAC_RAW, SKS_CMD_SEND,      16'h0040, 1, 1'b0, 8'h00},
         '{SKS_MODE_UDP,     SKS_CMD_SEND_KHW,  16'h0032, 1, 1'b0, 8'h00},
         '{SKS_MODE_IP_RAW,  SKS_CMD_SEND_KHW,  16'h0028, 1, 1'b0, 8'h02},
         '{SKS_MODE_TCP,     SKS_CMD_SEND_KHW,  16'h0028, 0, 1'b1, 8'h00},
         '{SKS_MODE_MAC_RAW, SKS_CMD_SEND_KHW,  16'h0028, 0, 1'b1, 8'h00},
         '{SKS_MODE_UDP,     SKS_CMD_KEEPALIVE, 16'h0000, 0, 1'b1, 8'h00}};
      {rstn, cmd_we, irq_clr_done, irq_clr_timeout} = 4'h0;
      {sock_open, ack_en} = 2'b11;
      {cmd_in, slow, sock_mode, send_len} = 36'h0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      #1;
      check({cmd_reg, sock_tx_free_size, sock_irq_flags, sock_state}, {8'h00, 16'h2000, 2'b00, 8'h00});
      check(seg_out, '0);
      repeat (2) @(posedge clk);
      // ordinary commands, one per row; each waits for send done or rejection first
      foreach (rows[i]) begin
         sock_mode <= rows[i].mode;
         slow <= rows[i].slow;
         ack_en <= rows[i].mode == SKS_MODE_TCP;
         n0 = seg_cnt;
         run_cmd(rows[i].cmd, rows[i].len, 3000);
         check(rej, rows[i].rej);
         check(done, !rows[i].rej);
         check(seg_cnt - n0, rows[i].segs);
         if (!rej) begin
            check(last_seg.len, exp_last(rows[i].len));
            check(last_seg.skip_resolve, rows[i].cmd == SKS_CMD_SEND_KHW);
            check(last_seg.dest_hw, DEST);
            if (rows[i].mode != SKS_MODE_TCP)
               check(sock_tx_free_size, SKS_TX_FREE_RESET - rows[i].len);
            @(posedge clk);
            #1;
            check(sock_tx_free_size, SKS_TX_FREE_RESET);
            clear(2'b01);
         end
      end
      // silent peer: ack wait runs out and the socket closes
      sock_mode <= SKS_MODE_TCP;
      ack_en <= 1'b0;
      run_cmd(SKS_CMD_SEND, 16'h000A, 3000);
      check(sock_irq_flags, 2'b10);
      check(sock_state, SKS_STATE_CLOSED);
      check(cyc >= ACK_SIM, 1'b1);
      clear(2'b10);
      // second reset, keep-alive refused until data has gone out
      rstn <= 1'b0;
      ack_en <= 1'b1;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      run_cmd(SKS_CMD_KEEPALIVE, 16'h0000, 20);
      check(rej, 1'b1);
      run_cmd(SKS_CMD_SEND, 16'h0014, 3000);
      check(done, 1'b1);
      clear(2'b01);
      n0 = keep_cnt;
      run_cmd(SKS_CMD_KEEPALIVE, 16'h0000, 3);
      repeat (3 * KEEP_SIM) @(posedge clk);
      #1;
      check(keep_cnt - n0 >= 2, 1'b1);
      final_report();
   end
endmodule : sks_send_ctrl_bench
